// ---- xcc_pkg.sv ----
// constants and register map of the crosspoint controller
`default_nettype none
package xcc_pkg;

  // device geometry: rows, address and connection word layout
  localparam int ROWS      = 17;
  localparam int ADDR_W    = 5;
  localparam int WORD_W    = 7;
  localparam int SEL_W     = 6;
  localparam int EN_BIT    = 6;
  localparam int INPUTS    = 33;
  localparam logic [ADDR_W-1:0] LAST_ROW = 5'h10;

  // controller register port
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;
  localparam logic [REG_AW-1:0] OFS_CTRL      = 8'h00;
  localparam logic [REG_AW-1:0] OFS_ROW_ADDR  = 8'h04;
  localparam logic [REG_AW-1:0] OFS_ROW_DATA  = 8'h08;
  localparam logic [REG_AW-1:0] OFS_CMD       = 8'h0C;
  localparam logic [REG_AW-1:0] OFS_STATUS    = 8'h10;
  localparam logic [REG_AW-1:0] OFS_READBACK  = 8'h14;
  localparam logic [REG_AW-1:0] OFS_ROWS_DONE = 8'h18;

  // command bits
  localparam int CMD_WRITE   = 0;
  localparam int CMD_UPDATE  = 1;
  localparam int CMD_READ    = 2;
  localparam int CMD_DISABLE = 3;

  // status bits
  localparam int ST_BUSY     = 0;
  localparam int ST_ALL_ROWS = 1;
  localparam int ST_ERROR    = 2;
  localparam int ST_RB_VALID = 3;

  // ctrl bits
  localparam int CTRL_BBM = 0;

  // timing, in ns
  localparam int CLK_NS      = 5;
  localparam int T_WE_NS     = 15;
  localparam int T_WE_UPD_NS = 10;
  localparam int T_UPD_NS    = 15;
  localparam int T_RST_NS    = 15;
  localparam int T_RDE_NS    = 15;
  localparam int T_RDD_NS    = 30;

  // least times, rounded up to whole cycles
  localparam int CYC_WE     = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_WE_UPD = (T_WE_UPD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_UPD    = (T_UPD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_RST    = (T_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_RDE    = (T_RDE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_RDD    = (T_RDD_NS + CLK_NS - 1) / CLK_NS;

  // timer load values: a state lasts load value plus one cycle
  localparam int TMR_W = 4;
  localparam logic [TMR_W-1:0] LD_ONE    = 4'h0;
  localparam logic [TMR_W-1:0] LD_WE     = TMR_W'(CYC_WE - 1);
  localparam logic [TMR_W-1:0] LD_WE_UPD = TMR_W'(CYC_WE_UPD - 1);
  localparam logic [TMR_W-1:0] LD_UPD    = TMR_W'(CYC_UPD - 1);
  localparam logic [TMR_W-1:0] LD_RST    = TMR_W'(CYC_RST - 1);
  localparam logic [TMR_W-1:0] LD_RDE    = TMR_W'(CYC_RDE - 1);
  localparam logic [TMR_W-1:0] LD_RDD    = TMR_W'(CYC_RDD - 1);

endpackage
`default_nettype wire

// ---- xcc_wait_timer.sv ----
// down counter that times each phase of a pin sequence
`timescale 1ns/1ps
`default_nettype none
module xcc_wait_timer #(
  parameter int                W    = 4,
  parameter logic [W-1:0]      INIT = '0
) (
  // system
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // load and status
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  output logic              expired
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  always_comb
  begin
    count_nxt = count_r;
    if (load)
    begin
      count_nxt = loadVal;
    end
    else if (count_r != '0)
    begin
      count_nxt = count_r - W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count_r <= INIT;
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

  assign expired = (count_r == '0);

endmodule
`default_nettype wire

// ---- xcc_crosspoint_ctrl.sv ----
// controller driving the crosspoint switch control pins from a register port
`timescale 1ns/1ps
`default_nettype none
// How it works
// - our data drivers off during readback
// - write enable returned high after each write
// - all seventeen rows written before update
// - never drive data while readback active
// - hold global disable low at power-up
// - disable active outputs before enabling others
module xcc_crosspoint_ctrl
  import xcc_pkg::*;
(
  // system
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // register port
  input  wire logic [xcc_pkg::REG_AW-1:0]  regAddr,
  input  wire logic [xcc_pkg::REG_DW-1:0]  regWrData,
  input  wire logic                        regWrStb,
  input  wire logic                        regRdStb,
  output logic      [xcc_pkg::REG_DW-1:0]  regRdData,
  // device control pins
  output logic      [xcc_pkg::ADDR_W-1:0]  devAddr,
  output logic      [xcc_pkg::WORD_W-1:0]  devDataOut,
  output logic                             devDataOe,
  input  wire logic [xcc_pkg::WORD_W-1:0]  devDataIn,
  output logic                             chipSelN,
  output logic                             writeEnableN,
  output logic                             updateN,
  output logic                             readbackEnableN,
  output logic                             globalDisableN
);

  typedef enum {
    S_PWRUP, S_IDLE, S_WR_SETUP, S_WR_PULSE, S_WR_HOLD, S_UPD_GAP,
    S_UPD_PULSE, S_RB_PULSE, S_RB_RELEASE, S_DIS_PULSE, S_END
  } xcc_state_t;

  // sequencer state and pins
  xcc_state_t              state_r, state_nxt;
  logic                    bbm_r, bbm_nxt;
  logic [ADDR_W-1:0]       devAddr_r, devAddr_nxt;
  logic [WORD_W-1:0]       devData_r, devData_nxt;
  logic                    oe_r, oe_nxt;
  logic                    cs_r, cs_nxt;
  logic                    we_r, we_nxt;
  logic                    upd_r, upd_nxt;
  logic                    re_r, re_nxt;
  logic                    gdis_r, gdis_nxt;
  logic                    tmrLoad;
  logic [TMR_W-1:0]        tmrVal;
  logic                    tmrDone;
  logic                    errSet, rowDoneSet, rbCapture;

  // software registers
  logic                    ctrlBbm_r, ctrlBbm_nxt;
  logic [ADDR_W-1:0]       rowAddr_r, rowAddr_nxt;
  logic [WORD_W-1:0]       rowData_r, rowData_nxt;
  logic                    err_r, err_nxt;
  logic                    rbValid_r, rbValid_nxt;
  logic [WORD_W-1:0]       rbData_r, rbData_nxt;
  logic [ROWS-1:0]         rowsDone_r, rowsDone_nxt;
  logic [REG_DW-1:0]       rdData_r, rdData_nxt;

  logic                    cmdWr, addrOk, allDone;

  assign cmdWr   = regWrStb && (regAddr == OFS_CMD);
  assign addrOk  = (rowAddr_r <= LAST_ROW);
  assign allDone = &rowsDone_r;

  xcc_wait_timer #(
    .W    (TMR_W),
    .INIT (LD_RST)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (tmrLoad),
    .loadVal (tmrVal),
    .expired (tmrDone)
  );

  always_comb
  begin
    state_nxt  = state_r;
    bbm_nxt    = bbm_r;
    tmrLoad    = 1'b0;
    tmrVal     = LD_ONE;
    errSet     = 1'b0;
    rowDoneSet = 1'b0;
    rbCapture  = 1'b0;
    // a command while a sequence runs is dropped and flagged
    if (cmdWr && (state_r != S_IDLE) && (regWrData[CMD_DISABLE:CMD_WRITE] != 4'h0))
    begin
      errSet = 1'b1;
    end
    unique case (state_r)
      S_PWRUP:
      begin
        if (tmrDone)
        begin
          state_nxt = S_IDLE;
        end
      end
      S_IDLE:
      begin
        if (cmdWr)
        begin
          if (regWrData[CMD_DISABLE])
          begin
            state_nxt = S_DIS_PULSE;
            tmrLoad   = 1'b1;
            tmrVal    = LD_RST;
          end
          else if (regWrData[CMD_WRITE])
          begin
            if (addrOk)
            begin
              state_nxt = S_WR_SETUP;
              tmrLoad   = 1'b1;
              tmrVal    = LD_ONE;
            end
            else
            begin
              errSet = 1'b1;
            end
          end
          else if (regWrData[CMD_UPDATE])
          begin
            if (!allDone)
            begin
              errSet = 1'b1;
            end
            else if (ctrlBbm_r)
            begin
              state_nxt = S_DIS_PULSE;
              bbm_nxt   = 1'b1;
              tmrLoad   = 1'b1;
              tmrVal    = LD_RST;
            end
            else
            begin
              state_nxt = S_UPD_GAP;
              tmrLoad   = 1'b1;
              tmrVal    = LD_WE_UPD;
            end
          end
          else if (regWrData[CMD_READ])
          begin
            if (addrOk)
            begin
              state_nxt = S_RB_PULSE;
              tmrLoad   = 1'b1;
              tmrVal    = LD_RDE;
            end
            else
            begin
              errSet = 1'b1;
            end
          end
        end
      end
      S_WR_SETUP:
      begin
        if (tmrDone)
        begin
          state_nxt  = S_WR_PULSE;
          tmrLoad    = 1'b1;
          tmrVal     = LD_WE;
          rowDoneSet = 1'b1;
        end
      end
      S_WR_PULSE:
      begin
        if (tmrDone)
        begin
          state_nxt = S_WR_HOLD;
          tmrLoad   = 1'b1;
          tmrVal    = LD_ONE;
        end
      end
      S_WR_HOLD:
      begin
        if (tmrDone)
        begin
          state_nxt = S_END;
        end
      end
      S_UPD_GAP:
      begin
        if (tmrDone)
        begin
          state_nxt = S_UPD_PULSE;
          tmrLoad   = 1'b1;
          tmrVal    = LD_UPD;
        end
      end
      S_UPD_PULSE:
      begin
        if (tmrDone)
        begin
          state_nxt = S_END;
          bbm_nxt   = 1'b0;
        end
      end
      S_RB_PULSE:
      begin
        if (tmrDone)
        begin
          rbCapture = 1'b1;
          state_nxt = S_RB_RELEASE;
          tmrLoad   = 1'b1;
          tmrVal    = LD_RDD;
        end
      end
      S_RB_RELEASE:
      begin
        // device may drive the bus until its release time is over
        if (tmrDone)
        begin
          state_nxt = S_IDLE;
        end
      end
      S_DIS_PULSE:
      begin
        if (tmrDone)
        begin
          if (bbm_r)
          begin
            state_nxt = S_UPD_GAP;
            tmrLoad   = 1'b1;
            tmrVal    = LD_WE_UPD;
          end
          else
          begin
            state_nxt = S_END;
          end
        end
      end
      S_END:
      begin
        state_nxt = S_IDLE;
      end
    endcase

    // pins decoded from the next state so they leave flip-flops aligned
    // address with the row
    devAddr_nxt = devAddr_r;
    devData_nxt = devData_r;
    if ((state_nxt == S_WR_SETUP) || (state_nxt == S_RB_PULSE))
    begin
      devAddr_nxt = rowAddr_r;
    end
    if (state_nxt == S_WR_SETUP)
    begin
      devData_nxt = rowData_r;
    end
    oe_nxt   = (state_nxt == S_WR_SETUP) || (state_nxt == S_WR_PULSE) ||
               (state_nxt == S_WR_HOLD);
    cs_nxt   = !(oe_nxt || (state_nxt == S_UPD_GAP) || (state_nxt == S_UPD_PULSE) ||
                 (state_nxt == S_RB_PULSE));
    we_nxt   = (state_nxt != S_WR_PULSE);
    upd_nxt  = (state_nxt != S_UPD_PULSE);
    re_nxt   = (state_nxt != S_RB_PULSE);
    gdis_nxt = !((state_nxt == S_PWRUP) || (state_nxt == S_DIS_PULSE));
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r   <= S_PWRUP;
      bbm_r     <= 1'b0;
      devAddr_r <= 5'h00;
      devData_r <= 7'h00;
      oe_r      <= 1'b0;
      cs_r      <= 1'b1;
      we_r      <= 1'b1;
      upd_r     <= 1'b1;
      re_r      <= 1'b1;
      gdis_r    <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      bbm_r     <= bbm_nxt;
      devAddr_r <= devAddr_nxt;
      devData_r <= devData_nxt;
      oe_r      <= oe_nxt;
      cs_r      <= cs_nxt;
      we_r      <= we_nxt;
      upd_r     <= upd_nxt;
      re_r      <= re_nxt;
      gdis_r    <= gdis_nxt;
    end
  end

  assign devAddr         = devAddr_r;
  assign devDataOut      = devData_r;
  assign devDataOe       = oe_r;
  assign chipSelN        = cs_r;
  assign writeEnableN    = we_r;
  assign updateN         = upd_r;
  assign readbackEnableN = re_r;
  assign globalDisableN  = gdis_r;

  always_comb
  begin
    ctrlBbm_nxt  = ctrlBbm_r;
    rowAddr_nxt  = rowAddr_r;
    rowData_nxt  = rowData_r;
    rbData_nxt   = rbData_r;
    rowsDone_nxt = rowsDone_r;
    err_nxt      = err_r;
    rbValid_nxt  = rbValid_r;
    if (regWrStb && (regAddr == OFS_CTRL))
    begin
      ctrlBbm_nxt = regWrData[CTRL_BBM];
    end
    if (regWrStb && (regAddr == OFS_ROW_ADDR))
    begin
      rowAddr_nxt = regWrData[ADDR_W-1:0];
    end
    if (regWrStb && (regAddr == OFS_ROW_DATA))
    begin
      rowData_nxt = regWrData[WORD_W-1:0];
    end
    // write one to clear; a new error in the same cycle wins
    if (regWrStb && (regAddr == OFS_STATUS) && regWrData[ST_ERROR])
    begin
      err_nxt = 1'b0;
    end
    if (errSet)
    begin
      err_nxt = 1'b1;
    end
    if (rowDoneSet)
    begin
      rowsDone_nxt[rowAddr_r] = 1'b1;
    end
    if (state_nxt == S_RB_PULSE)
    begin
      rbValid_nxt = 1'b0;
    end
    if (rbCapture)
    begin
      rbData_nxt  = devDataIn;
      rbValid_nxt = 1'b1;
    end
    rdData_nxt = '0;
    if (regRdStb)
    begin
      unique case (regAddr)
        OFS_CTRL:      rdData_nxt[CTRL_BBM] = ctrlBbm_r;
        OFS_ROW_ADDR:  rdData_nxt[ADDR_W-1:0] = rowAddr_r;
        OFS_ROW_DATA:  rdData_nxt[WORD_W-1:0] = rowData_r;
        OFS_STATUS:    rdData_nxt[ST_RB_VALID:ST_BUSY] =
                         {rbValid_r, err_r, allDone, state_r != S_IDLE};
        OFS_READBACK:  rdData_nxt[WORD_W-1:0] = rbData_r;
        OFS_ROWS_DONE: rdData_nxt[ROWS-1:0] = rowsDone_r;
        default:       rdData_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrlBbm_r  <= 1'b0;
      rowAddr_r  <= 5'h00;
      rowData_r  <= 7'h00;
      err_r      <= 1'b0;
      rbValid_r  <= 1'b0;
      rbData_r   <= 7'h00;
      rowsDone_r <= 17'h0_0000;
      rdData_r   <= 32'h0000_0000;
    end
    else
    begin
      ctrlBbm_r  <= ctrlBbm_nxt;
      rowAddr_r  <= rowAddr_nxt;
      rowData_r  <= rowData_nxt;
      err_r      <= err_nxt;
      rbValid_r  <= rbValid_nxt;
      rbData_r   <= rbData_nxt;
      rowsDone_r <= rowsDone_nxt;
      rdData_r   <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;

  // helper: global disable seen during the current sequence
  logic disSeen_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst || (state_r == S_IDLE))
    begin
      disSeen_r <= 1'b0;
    end
    else if (!globalDisableN)
    begin
      disSeen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_no_drive_rb;
    !readbackEnableN |-> !devDataOe;
  endproperty
  a_no_drive_rb: assert property (p_no_drive_rb) else $error("data driven in readback");

  property p_turnaround;
    $rose(readbackEnableN) |-> !devDataOe [*6];
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("bus reused too early");

  property p_we_width;
    $fell(writeEnableN) |-> !writeEnableN [*3] ##1 writeEnableN;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse wrong length");

  property p_strobe_cs;
    (!writeEnableN || !updateN || !readbackEnableN) |-> !chipSelN;
  endproperty
  a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");

  property p_pwrup_hold;
    $fell(sys_rst) |-> !globalDisableN [*3];
  endproperty
  a_pwrup_hold: assert property (p_pwrup_hold) else $error("power-up disable too short");

  property p_upd_width;
    $fell(updateN) |-> !updateN [*3] ##1 updateN;
  endproperty
  a_upd_width: assert property (p_upd_width) else $error("update pulse wrong length");

  property p_bad_addr;
    (cmdWr && (state_r == S_IDLE) && !addrOk && !regWrData[CMD_DISABLE] &&
     (regWrData[CMD_WRITE] || regWrData[CMD_READ])) |=>
      err_r ##0 (writeEnableN && chipSelN) [*8];
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("high row not refused");

  property p_early_update;
    (cmdWr && (state_r == S_IDLE) && !allDone && regWrData[CMD_UPDATE] &&
     !regWrData[CMD_WRITE] && !regWrData[CMD_DISABLE]) |=> updateN [*8];
  endproperty
  a_early_update: assert property (p_early_update) else $error("update before all rows");

  property p_bbm;
    ($fell(updateN) && bbm_r) |-> disSeen_r;
  endproperty
  a_bbm: assert property (p_bbm) else $error("update without prior disable");

  property p_rb_sample;
    $fell(readbackEnableN) |-> ##[1:8] rbValid_r;
  endproperty
  a_rb_sample: assert property (p_rb_sample) else $error("readback never captured");

  c_write: cover property ($rose(writeEnableN) ##1 !devDataOe [*1]);
  c_update: cover property ($rose(updateN) && allDone);
  c_readback: cover property ($rose(rbValid_r));
  c_bbm_update: cover property ($fell(updateN) && bbm_r);

endmodule
`default_nettype wire

// ---- xcc_dev_model.sv ----
// behavioural model of the crosspoint latch bank behind the control pins
`timescale 1ns/1ps
`default_nettype none
module xcc_dev_model
  import xcc_pkg::*;
(
  // control pins
  input  wire logic [xcc_pkg::ADDR_W-1:0] devAddr,
  input  wire logic                       chipSelN,
  input  wire logic                       writeEnableN,
  input  wire logic                       updateN,
  input  wire logic                       readbackEnableN,
  input  wire logic                       globalDisableN,
  // controller side of the data pins
  input  wire logic [xcc_pkg::WORD_W-1:0] ctrlData,
  input  wire logic                       ctrlOe,
  // resolved level of the data pins
  output logic      [xcc_pkg::WORD_W-1:0] pinLevel
);
  logic [WORD_W-1:0] firstRank  [ROWS];
  logic [WORD_W-1:0] secondRank [ROWS];
  logic [WORD_W-1:0] lastPin = 7'h55;
  logic [WORD_W-1:0] rbWord;
  logic              devDrive;
  int                clashes = 0;

  function automatic logic outLive(input int i);
    return secondRank[i][EN_BIT] && (secondRank[i][SEL_W-1:0] < INPUTS);
  endfunction

  always @(devAddr or chipSelN or writeEnableN or updateN or readbackEnableN
           or globalDisableN or ctrlData or ctrlOe)
  begin
    devDrive = !chipSelN && !readbackEnableN;
    rbWord = (devAddr <= LAST_ROW) ? secondRank[devAddr] : '0;
    if (ctrlOe && devDrive)
      clashes++;
    // undriven pins float: show the inverse of the last driven value, not the value itself
    if (ctrlOe)
      pinLevel = ctrlData;
    else if (devDrive)
      pinLevel = rbWord;
    else
      pinLevel = ~lastPin;
    if (ctrlOe || devDrive)
      lastPin = pinLevel;
    if (!chipSelN && !writeEnableN && devAddr <= LAST_ROW)
      firstRank[devAddr] = pinLevel;
    if (!chipSelN && !updateN)
      for (int i = 0; i < ROWS; i++)
        secondRank[i] = firstRank[i];
    if (!globalDisableN)
      for (int i = 0; i < ROWS; i++)
        secondRank[i][EN_BIT] = 1'b0;
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the crosspoint controller against a device model
`timescale 1ns/1ps
`default_nettype none
module tb_top import xcc_pkg::*;;
  logic              clk;
  logic              sys_rst;
  logic [REG_AW-1:0] regAddr;
  logic [REG_DW-1:0] regWrData;
  logic              regWrStb;
  logic              regRdStb;
  logic [REG_DW-1:0] regRdData;
  logic [ADDR_W-1:0] devAddr;
  logic [WORD_W-1:0] devDataOut;
  logic              devDataOe;
  logic [WORD_W-1:0] pinLevel;
  logic              chipSelN;
  logic              writeEnableN;
  logic              updateN;
  logic              readbackEnableN;
  logic              globalDisableN;
  logic [REG_DW-1:0] rd;
  int                mismatches = 0;
  int                checks = 0;
  int                seed = 32'hd355;
  int                expPend [ROWS];

  xcc_crosspoint_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .devAddr(devAddr), .devDataOut(devDataOut),
    .devDataOe(devDataOe), .devDataIn(pinLevel), .chipSelN(chipSelN),
    .writeEnableN(writeEnableN), .updateN(updateN),
    .readbackEnableN(readbackEnableN), .globalDisableN(globalDisableN));

  xcc_dev_model u_dev (.devAddr(devAddr), .chipSelN(chipSelN),
    .writeEnableN(writeEnableN), .updateN(updateN),
    .readbackEnableN(readbackEnableN), .globalDisableN(globalDisableN),
    .ctrlData(devDataOut), .ctrlOe(devDataOe), .pinLevel(pinLevel));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [REG_DW-1:0] seen, input logic [REG_DW-1:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic regWrite(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge clk);
    regWrStb  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrStb  <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic regRead(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
    @(posedge clk);
    regRdStb <= 1'b1;
    regAddr  <= a;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic cmd(input int bitPos);
    regWrite(OFS_CMD, REG_DW'(1) << bitPos);
  endtask

  // bounded poll: a stuck busy flag must not hang the run
  task automatic waitIdle();
    logic [REG_DW-1:0] st;
    for (int n = 0; n < 40; n++)
    begin
      regRead(OFS_STATUS, st);
      if (st[ST_BUSY] === 1'b0)
        return;
    end
    check(st, 32'h0000_0000);
  endtask

  task automatic errCheck(input logic e);
    logic [REG_DW-1:0] st;
    regRead(OFS_STATUS, st);
    check(st[ST_ERROR], e);
    regWrite(OFS_STATUS, REG_DW'(1) << ST_ERROR);
  endtask

  task automatic writeRow(input int r, input int d);
    regWrite(OFS_ROW_ADDR, REG_DW'(r));
    regWrite(OFS_ROW_DATA, REG_DW'(d));
    cmd(CMD_WRITE);
    waitIdle();
  endtask

  initial
  begin
    #200000;
    mismatches++;
    conclude();
  end

  initial
  begin
    sys_rst   = 1'b1;
    regAddr   = '0;
    regWrData = '0;
    regWrStb  = 1'b0;
    regRdStb  = 1'b0;
    repeat (16) @(posedge clk);
    check(globalDisableN, 1'b0);
    sys_rst <= 1'b0;
    waitIdle();
    for (int r = 0; r < ROWS; r++)
      check(u_dev.secondRank[r][EN_BIT], 1'b0);
    // update before every row is written
    cmd(CMD_UPDATE);
    waitIdle();
    errCheck(1'b1);
    writeRow(ROWS, 32'h0000_0041);
    errCheck(1'b1);
    for (int r = 0; r < ROWS; r++)
    begin
      expPend[r] = (r == 15) ? 32'h0000_0063 : ($random(seed) & 32'h0000_007f);
      writeRow(r, expPend[r]);
      check(u_dev.firstRank[r], expPend[r][6:0]);
      check(u_dev.secondRank[r][EN_BIT], 1'b0);
    end
    regRead(OFS_ROWS_DONE, rd);
    check(rd, 32'h0001_ffff);
    cmd(CMD_UPDATE);
    waitIdle();
    for (int r = 0; r < ROWS; r++)
      check(u_dev.secondRank[r], expPend[r][6:0]);
    check(u_dev.outLive(15), 1'b0);
    for (int r = 0; r < ROWS; r++)
    begin
      regWrite(OFS_ROW_ADDR, REG_DW'(r));
      cmd(CMD_READ);
      waitIdle();
      regRead(OFS_READBACK, rd);
      check(rd, expPend[r]);
    end
    regRead(OFS_STATUS, rd);
    check(rd[ST_RB_VALID], 1'b1);
    cmd(CMD_DISABLE);
    waitIdle();
    for (int r = 0; r < ROWS; r++)
    begin
      check(u_dev.secondRank[r], {1'b0, expPend[r][5:0]});
      check(u_dev.firstRank[r], expPend[r][6:0]);
    end
    // a command while a sequence runs is dropped and flagged
    cmd(CMD_DISABLE);
    cmd(CMD_DISABLE);
    waitIdle();
    errCheck(1'b1);
    // readback of a row above sixteen is refused
    regWrite(OFS_ROW_ADDR, REG_DW'(ROWS));
    cmd(CMD_READ);
    errCheck(1'b1);
    // break-before-make update with one row changed
    regWrite(OFS_CTRL, 32'h0000_0001);
    expPend[0] = ($random(seed) & 32'h0000_003f) | 32'h0000_0040;
    writeRow(0, expPend[0]);
    cmd(CMD_UPDATE);
    waitIdle();
    for (int r = 0; r < ROWS; r++)
      check(u_dev.secondRank[r], expPend[r][6:0]);
    regRead(OFS_CTRL, rd);
    check(rd, 32'h0000_0001);
    regRead(OFS_ROW_DATA, rd);
    check(rd, expPend[0]);
    errCheck(1'b0);
    regRead(8'h1c, rd);
    check(rd, 32'h0000_0000);
    check(u_dev.clashes, 32'h0000_0000);
    conclude();
  end
endmodule
`default_nettype wire
